/* File: core/eeprom_pkg.sv */
// Purpose: Shared constants and types for the serial EEPROM command engine
// Assumes: 256 x 16 organisation, serial fields sent MSB first
// Notes:   Program phase time is a plain default, shortened in simulation
package eeprom_pkg;

    localparam int DATA_W    = 16;                  // Word width
    localparam int ADDR_W    = 8;                   // Address width
    localparam int MEM_DEPTH = 256;                 // Number of words
    localparam int CMD_BITS  = 10;                  // Opcode plus address bits
    localparam int CNT_W     = 5;                   // Serial bit counter width

    localparam logic [CNT_W-1:0] CMD_LAST  = 5'h09; // Last opcode/address bit
    localparam logic [CNT_W-1:0] DATA_LAST = 5'h0f; // Last data bit
    localparam logic [CNT_W-1:0] WORD_LAST = 5'h0f; // Last read data bit
    localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00; // Counter start

    localparam logic [1:0] OP_READ    = 2'h2;       // Opcode 10
    localparam logic [1:0] OP_WRITE   = 2'h1;       // Opcode 01
    localparam logic [1:0] OP_ERASE   = 2'h3;       // Opcode 11, single erase
    localparam logic [1:0] OP_SPECIAL = 2'h0;       // Opcode 00
    localparam logic [1:0] SEL_ERASE_ALL_CMD   = 2'h2;       // Address MSBs 10
    localparam logic [1:0] SEL_DIS    = 2'h0;       // Address MSBs 00
    localparam logic [1:0] SEL_EN     = 2'h3;       // Address MSBs 11
    localparam logic [1:0] SEL_WRITE_ALL_CMD   = 2'h1;       // Address MSBs 01

    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff; // Erased cell value
    localparam logic [DATA_W-1:0] ZERO_WORD   = 16'h0000; // Cleared word

    localparam int SYS_PERIOD_NS = 8;               // System clock period
    localparam int PHASE_TIME_NS = 1000000;         // Erase or program phase

    // Commands handed from the link to the system domain
    typedef enum logic [2:0] {
        cmd_read,
        cmd_write,
        erase_all_cmd,
        write_all_cmd,
        program_enable_cmd,
        program_disable_cmd
    } cmd_kind_t;

    // One command word crossing the domains
    typedef struct packed {
        cmd_kind_t         kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;

    // Serial link states
    typedef enum logic [2:0] {
        l_idle, l_cmd, l_data, l_dummy, l_read, l_done
    } link_state_t;

    // Self-timed engine states
    typedef enum logic [1:0] {
        e_idle, e_erase, e_prog
    } eng_state_t;

endpackage

/* File: core/sync_2ff.sv */
// Purpose: Two-flop synchroniser for levels entering the system domain
// Assumes: Each bit is an independent level
// Notes:   The first stage feeds only the second stage
module sync_2ff #(
    parameter int W = 1                       // Number of bits
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;                       // First stage

    // Two stages, cleared at reset
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // sync_2ff

/* File: core/eeprom_core.sv */
// Purpose: Command engine of a 3-wire serial EEPROM, 256 x 16
// Assumes: serial_clk is the master's clock, may stop outside frames
// Notes:   Serial decode runs on serial_clk; array and timed cycles on clk_sys
// Overview of operation
// - Erase all sets every bit to one
// - Erase all uses the common erase phase
// - Erase all starts at last address edge
// - Erase all shows ready/busy after reselect
// - Programming disabled after power up
// - Enable needed; stays until disable
// - Reads ignore the enable latch
// - Read sends dummy zero then word
// - Read bits change on rising clock
// - Continued clocking reads next locations
// - Write data follows address, gets stored
// - Write erases then programs, self-timed
// - Status low busy, high ready
// - Write shows status after reselect
// - Write all programs every location
// - Write all starts at last data edge
// - Write all erases first, needs enable
// - Write all shows status after reselect
// - Start bit is first high data input
// - Opcodes and special selects decode as listed, but opcode 11 (single erase) is ignored
// - Output high impedance outside read or status
// - Low select resets the serial logic
module eeprom_core
    import eeprom_pkg::*;
#(
    parameter int PHASE_CYCLES = eeprom_pkg::PHASE_TIME_NS / eeprom_pkg::SYS_PERIOD_NS
) (
    // System clock and power-on reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Serial link from the master
    input  wire logic serial_clk,
    input  wire logic chip_sel,
    input  wire logic serial_in,
    // Serial data out, three-state
    output logic      serial_out,
    output logic      serial_out_oe
);
    import eeprom_pkg::*;

    localparam int TIMER_W = $clog2(PHASE_CYCLES + 1);
    localparam logic [TIMER_W-1:0] PHASE_LOAD = TIMER_W'(PHASE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] TIMER_END  = '0;

    // Link domain state
    wire logic           link_rst_n = nrst & chip_sel; // Deselect resets link
    link_state_t         lstate;                       // Serial phase
    logic [CNT_W-1:0]    bit_cnt;                      // Bits in this phase
    logic [DATA_W-1:0]   in_sr;                        // Incoming bits
    logic [1:0]          op_q;                         // Latched opcode
    logic [ADDR_W-1:0]   addr_q;                       // Latched address
    logic                started;                      // Start bit seen
    logic                rd_drive;                     // Read data on pin
    logic                rd_bit;                       // Read data bit
    logic [DATA_W-1:0]   out_sr;                       // Read shift register
    cmd_t                cmd_q;                        // Command to system side
    logic                cmd_tog;                      // Flips per command
    logic                next_issue;                   // Command this edge
    cmd_t                next_cmd;                     // Its contents
    logic [CMD_BITS-1:0] cw;                           // Opcode and address word
    logic [DATA_W-1:0]   dw;                           // Completed data word

    // System domain state
    logic [DATA_W-1:0]   mem [MEM_DEPTH];              // The array
    logic [DATA_W-1:0]   rd_word;                      // Word fetched for reads
    logic [4:0]          sync_q;                       // Synchronised levels
    logic                cs_s, tog_s, drive_s, bit_s, start_s;
    logic                tog_d;                        // Toggle history
    logic                start_d;                      // Start history
    logic                cmd_fire;                     // New command pulse
    logic                prog_en;                      // Programming enabled
    eng_state_t          estate;                       // Timed cycle phase
    logic [TIMER_W-1:0]  timer;                        // Phase countdown
    logic                all_q;                        // Whole array target
    logic                prog_q;                       // Program after erase
    logic [ADDR_W-1:0]   eng_addr;                     // Target held for the cycle
    logic [DATA_W-1:0]   eng_data;                     // Word held for the cycle
    logic                armed;                        // Status reporting due
    logic                ready_busy_status;            // High when ready

    assign cw = {in_sr[CMD_BITS-2:0], serial_in};
    assign dw = {in_sr[DATA_W-2:0], serial_in};

    // Serial phase sequencing, rising serial clock
    always_ff @(posedge serial_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            lstate  <= l_idle;
            bit_cnt <= CNT_ZERO;
            in_sr   <= ZERO_WORD;
            op_q    <= OP_SPECIAL;
            addr_q  <= '0;
            started <= 1'b0;
        end
        else
        begin
            unique case (lstate)
                l_idle:
                begin
                    // Select is high here, so a high input is the start bit
                    if (serial_in)
                    begin
                        lstate  <= l_cmd;
                        started <= 1'b1;
                        bit_cnt <= CNT_ZERO;
                    end
                end
                l_cmd:
                begin
                    in_sr   <= dw;
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == CMD_LAST)
                    begin
                        op_q    <= cw[CMD_BITS-1 -: 2];
                        addr_q  <= cw[ADDR_W-1:0];
                        bit_cnt <= CNT_ZERO;
                        // Opcode decode picks the following phase
                        if (cw[CMD_BITS-1 -: 2] == OP_READ)
                            lstate <= l_dummy;
                        else if (cw[CMD_BITS-1 -: 2] == OP_WRITE
                                 || (cw[CMD_BITS-1 -: 2] == OP_SPECIAL
                                     && cw[ADDR_W-1 -: 2] == SEL_WRITE_ALL_CMD))
                            lstate <= l_data;
                        else
                            lstate <= l_done;
                    end
                end
                l_data:
                begin
                    in_sr   <= dw;
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == DATA_LAST)
                        lstate <= l_done;
                end
                l_dummy:
                    lstate <= l_read;
                l_read:
                begin
                    // Word boundary moves on to the next location
                    bit_cnt <= (bit_cnt == WORD_LAST) ? CNT_ZERO : bit_cnt + 1'b1;
                    if (bit_cnt == CNT_ZERO)
                        addr_q <= addr_q + 1'b1;
                end
                l_done:
                    lstate <= l_done;
            endcase
        end
    end

    // Read data shifted out on each rising serial clock
    always_ff @(posedge serial_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            rd_drive <= 1'b0;
            rd_bit   <= 1'b0;
            out_sr   <= ZERO_WORD;
        end
        else if (lstate == l_dummy)
        begin
            rd_drive <= 1'b1;
            rd_bit   <= 1'b0;
        end
        else if (lstate == l_read && bit_cnt == CNT_ZERO)
        begin
            // Fetched word is stable a full serial period after its request
            rd_bit <= rd_word[DATA_W-1];
            out_sr <= {rd_word[DATA_W-2:0], 1'b0};
        end
        else if (lstate == l_read)
        begin
            rd_bit <= out_sr[DATA_W-1];
            out_sr <= {out_sr[DATA_W-2:0], 1'b0};
        end
    end

    // Which edge hands a command to the system side
    always_comb
    begin
        next_issue = 1'b0;
        next_cmd   = '{kind: cmd_read, addr: addr_q, data: dw};
        if (lstate == l_cmd && bit_cnt == CMD_LAST)
        begin
            next_cmd.addr = cw[ADDR_W-1:0];
            if (cw[CMD_BITS-1 -: 2] == OP_READ)
                next_issue = 1'b1;
            else if (cw[CMD_BITS-1 -: 2] == OP_SPECIAL && cw[ADDR_W-1 -: 2] != SEL_WRITE_ALL_CMD)
            begin
                next_issue = 1'b1;
                if (cw[ADDR_W-1 -: 2] == SEL_ERASE_ALL_CMD)
                    next_cmd.kind = erase_all_cmd;
                else if (cw[ADDR_W-1 -: 2] == SEL_EN)
                    next_cmd.kind = program_enable_cmd;
                else
                    next_cmd.kind = program_disable_cmd;
            end
        end
        else if (lstate == l_data && bit_cnt == DATA_LAST)
        begin
            next_issue    = 1'b1;
            next_cmd.kind = (op_q == OP_WRITE) ? cmd_write : write_all_cmd;
        end
        else if (lstate == l_read && bit_cnt == CNT_ZERO)
        begin
            next_issue    = 1'b1;
            next_cmd.addr = addr_q + 1'b1;
        end
    end

    // Command word and toggle; kept through deselect so no false event
    always_ff @(posedge serial_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_q   <= '{kind: cmd_read, addr: '0, data: ZERO_WORD};
            cmd_tog <= 1'b0;
        end
        else if (next_issue)
        begin
            cmd_q   <= next_cmd;
            cmd_tog <= ~cmd_tog;
        end
    end

    // Link levels into the system domain
    sync_2ff #(.W(5)) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       ({chip_sel, cmd_tog, rd_drive, rd_bit, started}),
        .q       (sync_q)
    );
    assign {cs_s, tog_s, drive_s, bit_s, start_s} = sync_q;
    assign cmd_fire          = tog_s ^ tog_d;
    assign ready_busy_status = (estate == e_idle);

    // Edge history of synchronised levels
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tog_d   <= 1'b0;
            start_d <= 1'b0;
        end
        else
        begin
            tog_d   <= tog_s;
            start_d <= start_s;
        end
    end

    // Enable latch, disabled from power-up
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            prog_en <= 1'b0;
        else if (cmd_fire && cmd_q.kind == program_enable_cmd)
            prog_en <= 1'b1;
        else if (cmd_fire && cmd_q.kind == program_disable_cmd)
            prog_en <= 1'b0;
    end

    // Self-timed erase then program engine
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            estate   <= e_idle;
            timer    <= TIMER_END;
            all_q    <= 1'b0;
            prog_q   <= 1'b0;
            eng_addr <= '0;
            eng_data <= ZERO_WORD;
        end
        else
        begin
            unique case (estate)
                e_idle:
                begin
                    // Disabled latch drops programming commands
                    if (cmd_fire && prog_en && cmd_q.kind inside {cmd_write, erase_all_cmd, write_all_cmd})
                    begin
                        estate <= e_erase;
                        timer  <= PHASE_LOAD;
                        all_q  <= (cmd_q.kind != cmd_write);
                        prog_q <= (cmd_q.kind != erase_all_cmd);
                        // Held copies stop a later read from retargeting a busy cycle
                        eng_addr <= cmd_q.addr;
                        eng_data <= cmd_q.data;
                    end
                end
                e_erase:
                begin
                    timer <= timer - 1'b1;
                    if (timer == TIMER_END)
                    begin
                        estate <= prog_q ? e_prog : e_idle;
                        timer  <= PHASE_LOAD;
                    end
                end
                e_prog:
                begin
                    timer <= timer - 1'b1;
                    if (timer == TIMER_END)
                        estate <= e_idle;
                end
            endcase
        end
    end

    // Array updates at the end of each phase; contents survive reset
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < MEM_DEPTH; i++)
        begin
            if (timer == TIMER_END && (all_q || eng_addr == ADDR_W'(i)))
            begin
                if (estate == e_erase)
                    mem[i] <= ERASED_WORD;
                else if (estate == e_prog)
                    mem[i] <= eng_data;
            end
        end
    end

    // Word fetch for the read path, whatever the latch says
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rd_word <= ZERO_WORD;
        else if (cmd_fire && cmd_q.kind == cmd_read)
            rd_word <= mem[cmd_q.addr];
    end

    // Status due after a started cycle, until the next start bit
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            armed <= 1'b0;
        else if (estate == e_idle && cmd_fire && prog_en
                 && cmd_q.kind inside {cmd_write, erase_all_cmd, write_all_cmd})
            armed <= 1'b1;
        else if (start_s && !start_d)
            armed <= 1'b0;
    end

    // Pin driver: read data, else status, else released
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end
        else
        begin
            serial_out_oe <= cs_s && (drive_s || (armed && !start_s));
            serial_out    <= drive_s ? bit_s : ready_busy_status;
        end
    end

    sequence s_write_go;
        cmd_fire && prog_en && estate == e_idle && cmd_q.kind == cmd_write;
    endsequence

    sequence s_erase_end;
        estate == e_erase && timer == TIMER_END && all_q;
    endsequence

    a_erase_all_ones: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_erase_end |=> mem[0] == ERASED_WORD && mem[MEM_DEPTH-1] == ERASED_WORD)
        else $error("array not erased to ones");

    a_write_phases: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_write_go |=> estate == e_erase && !ready_busy_status ##1 timer == PHASE_LOAD - 1'b1)
        else $error("write cycle did not start with erase");

    a_disabled_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
        (cmd_fire && !prog_en && estate == e_idle) |=> estate == e_idle && !armed)
        else $error("disabled programming started a cycle");

    a_enable_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
        (cmd_fire && cmd_q.kind == program_enable_cmd) |=> prog_en [*2])
        else $error("enable did not latch");

    a_status_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        (cs_s && armed && !start_s && !drive_s && estate != e_idle) ##1 estate != e_idle
        |-> serial_out_oe && !serial_out)
        else $error("busy status not low");

    a_release_deselect: assert property (@(posedge clk_sys) disable iff (!nrst)
        !cs_s |=> !serial_out_oe)
        else $error("output driven while deselected");

    a_read_fetch: assert property (@(posedge clk_sys) disable iff (!nrst)
        (cmd_fire && cmd_q.kind == cmd_read && estate == e_idle) |=> rd_word == mem[$past(cmd_q.addr)])
        else $error("read fetch wrong word");

    a_start_wait: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
        (lstate == l_idle && !serial_in) |=> lstate == l_idle && !started)
        else $error("start taken without high input");

    a_dummy_zero: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
        lstate == l_dummy |=> rd_drive && !rd_bit ##1 rd_bit == $past(rd_word[DATA_W-1]))
        else $error("dummy zero or first bit wrong");

endmodule // eeprom_core

/* File: tb/serial_master.sv */
// Purpose: Model of the serial bus master driving the EEPROM link
// Assumes: Link clock period 160 ns, clock idles low outside frames
// Notes:   Data out is sampled just before each rising link edge
module serial_master (
    // Link outputs
    output logic      serial_clk,
    output logic      chip_sel,
    output logic      serial_in,
    // Device data out
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic pin;  // Line as seen; inverted while the device does not drive

    // A released line shows the opposite level, so late or early samples stand out
    assign pin = serial_out_oe ? serial_out : ~serial_out;

    // Idle link at time zero
    initial
    begin
        serial_clk = 1'b0;
        chip_sel   = 1'b0;
        serial_in  = 1'b0;
    end

    // Select level; a deselect is held low long enough before reselect
    task automatic hold(input logic s);
        chip_sel = s;
        if (!s)
            #250;
    endtask

    // Select, clock n bits MSB first, capture data out, then deselect
    task automatic frame(input int n, input logic [63:0] v, output logic [63:0] got);
        #3.7;
        hold(1'b1);
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in = v[i];
            #80 got = {got[62:0], pin};
            serial_clk = 1'b1;
            #80 serial_clk = 1'b0;
        end
        #80 got = {got[62:0], pin};
        serial_in = ~serial_in;
        hold(1'b0);
    endtask
endmodule // serial_master

/* File: tb/serial_eeprom_command_engine_bench.sv */
// Purpose: Self-checking bench for the serial EEPROM command engine
// Assumes: Erase and program phases shortened to PHASE cycles
// Notes:   Expected array kept in mem; random data from a fixed seed
module serial_eeprom_command_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import eeprom_pkg::*;

    localparam int PHASE = 100;          // Shortened phase length
    logic              clk_sys;          // System clock
    logic              nrst;             // Power-on reset
    logic              serial_clk;       // Link clock
    logic              chip_sel;         // Select
    logic              serial_in;        // Data to the device
    logic              serial_out;       // Data or status out
    logic              serial_out_oe;    // Drive enable of data out
    logic [DATA_W-1:0] mem [MEM_DEPTH];  // Expected array contents
    logic [63:0]       got;              // Captured data out bits
    logic [7:0]        a;                // Address under test
    logic [DATA_W-1:0] d;                // Write-all data word
    int                errors;           // Mismatch count
    int                tests_run;        // Comparison count

    // System clock, 8 ns period
    always #4 clk_sys = ~clk_sys;

    // Device under test
    eeprom_core #(.PHASE_CYCLES(PHASE)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .serial_clk(serial_clk),
        .chip_sel(chip_sel), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // Master on the far side of the link
    serial_master i_master (.serial_clk(serial_clk), .chip_sel(chip_sel), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // Compare one value and report a mismatch
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Start bit, opcode and address
    function automatic logic [10:0] cmd(input logic [1:0] op, input logic [7:0] adr);
        return {1'b1, op, adr};
    endfunction

    // Command with data word, three idle zeros ahead of the start bit
    task automatic send_data(input logic [1:0] op, input logic [7:0] adr, input logic [15:0] dat);
        i_master.frame(30, {cmd(op, adr), dat}, got);
    endtask

    // Special command without data
    task automatic special(input logic [1:0] sel);
        i_master.frame(14, cmd(OP_SPECIAL, {sel, 6'h00}), got);
    endtask

    // Reselect; min < 0 means no status, else busy for at least min cycles
    task automatic status(input int min);
        int n;
        n = 0;
        i_master.hold(1'b1);
        repeat (6) @(negedge clk_sys);
        check("status_oe", serial_out_oe, min >= 0);
        if (min >= 0)
        begin
            check("status_busy", serial_out, 1'b0);
            while (serial_out !== 1'b1 && n < 4 * PHASE)
            begin
                @(negedge clk_sys);
                n++;
            end
            check("status_ready", serial_out, 1'b1);
            check("busy_long", n >= min, 1'b1);
        end
        i_master.hold(1'b0);
        check("oe_released", serial_out_oe, 1'b0);
    endtask

    // Sequential read of two words with the dummy zero ahead
    task automatic read2(input logic [7:0] adr);
        i_master.frame(47, cmd(OP_READ, adr) << 33, got);
        check("read_words", got[32:0], {1'b0, mem[adr], mem[adr + 8'h01]});
    endtask

    // Write one word and wait for ready
    task automatic write(input logic [7:0] adr, input logic [15:0] dat);
        send_data(OP_WRITE, adr, dat);
        status(120);
        mem[adr] = dat;
    endtask

    // Print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        errors = 0;
        tests_run = 0;
        void'($urandom(32'h54d968cc));
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        // Write all before any enable does nothing
        send_data(OP_SPECIAL, {SEL_WRITE_ALL_CMD, 6'h00}, 16'($urandom));
        status(-1);
        $display("test power-up lock done");
        special(SEL_EN);
        special(SEL_ERASE_ALL_CMD);
        status(30);
        foreach (mem[i]) mem[i] = ERASED_WORD;
        read2(8'($urandom));
        $display("test erase all done");
        d = 16'($urandom);
        send_data(OP_SPECIAL, {SEL_WRITE_ALL_CMD, 6'h00}, d);
        status(120);
        foreach (mem[i]) mem[i] = d;
        read2(8'hff);
        $display("test write all done");
        for (int i = 0; i < 5; i++)
        begin
            a = (i == 0) ? 8'hff : 8'($urandom);
            write(a, 16'($urandom));
            write(a + 8'h01, 16'($urandom));
            read2(a);
        end
        $display("test writes done");
        // Frame cut short by deselect stores nothing
        i_master.frame(23, {cmd(OP_WRITE, a), 16'h0000} >> 7, got);
        status(-1);
        read2(a);
        special(SEL_DIS);
        send_data(OP_WRITE, a, ~mem[a]);
        status(-1);
        read2(a);
        $display("test disable done");
        summarize();
    end

    // Watchdog against a hang
    initial
    begin
        #600us;
        errors++;
        summarize();
    end
endmodule // serial_eeprom_command_engine_bench
